// >>> design/tlbx_cfg.svh
`ifndef TLBX_CFG_SVH
`define TLBX_CFG_SVH

`define TLBX_AW        5
`define TLBX_OFF_HI    5'h00
`define TLBX_OFF_LO    5'h04
`define TLBX_OFF_IDX   5'h08
`define TLBX_OFF_RND   5'h0c
`define TLBX_OFF_STAT  5'h10

`define TLBX_HI_VPN    31:12
`define TLBX_HI_PID    11:6
`define TLBX_LO_PFN    31:12
`define TLBX_LO_N      11
`define TLBX_LO_D      10
`define TLBX_LO_V      9
`define TLBX_LO_G      8
`define TLBX_IDX_SEL   13:8
`define TLBX_IDX_FAIL  31
`define TLBX_RND_SEL   13:8
`define TLBX_STAT_TS   0

`define TLBX_VA_VPN    31:12
`define TLBX_VA_OFF    11:0
`define TLBX_VA_USER   31
`define TLBX_VA_TOP2   31:30
`define TLBX_KMAP_CODE 2'h3

`define TLBX_RND_TOP   6'h3f
`define TLBX_RND_FLOOR 6'h08

`endif

// >>> design/tlbx_pkg.sv
package tlbx_pkg;

    typedef enum logic [2:0] {
        TLBX_OP_NONE,
        TLBX_OP_PROBE,
        TLBX_OP_READ,
        TLBX_OP_WRITE_IDX,
        TLBX_OP_WRITE_RND
    } tlbx_op_t;

    typedef enum logic [1:0] {
        TLBX_ACC_FETCH,
        TLBX_ACC_LOAD,
        TLBX_ACC_STORE
    } tlbx_acc_t;

    typedef struct packed {
        logic        valid;
        tlbx_acc_t   acc;
        logic [31:0] vaddr;
    } tlbx_req_t;

    typedef struct packed {
        logic        valid;
        logic        mapped;
        logic        hit;
        logic [31:0] paddr;
        logic        uncached;
        logic        writable;
        logic        page_valid;
        logic        user_miss;
        logic        load_miss;
        logic        store_miss;
        logic        modify;
    } tlbx_resp_t;

endpackage

// >>> design/tlbx_tlb.sv
// Operation
// - Only user and kernel mapped segment addresses go through the buffer.
// - Pages are 4 KB; frame number replaces page number, offset kept.
// - Sixty-four fully associative entries compared in parallel per mapped reference.
// - High half holds page number 63..44, process tag 43..38, zeros below.
// - Low half holds frame 31..12, uncached 11, writable 10, valid 9, global 8.
// - Reserved bits read zero; software writes zeros there.
// - Match needs equal page number and global set or equal process tag.
// - A hit outputs frame number with uncached, writable and valid flags.
// - No match on a mapped address signals a translation miss.
// - Hit on an invalid entry raises load or store miss.
// - Store hitting valid read-only entry raises modify; entry stays unchanged.
// - Uncached hit makes the access bypass the cache to main memory.
// - Index register holds a 6-bit selector and a probe fail flag on top.
// - Random counter decrements each enabled cycle, staying within 63 down to 8.
// - Random counter is preset to 63 at reset.
// - Probe loads index on a match, otherwise sets probe fail flag.
// - Read copies the indexed entry into the high and low registers.
// - Indexed write stores high and low registers into the indexed entry.
// - Random write stores high and low registers into the random entry.
// - Multiple matches set the shutdown flag and stop mapped translation.
// - Shutdown flag stays set until reset; software cannot clear it.
// - Shutdown flag reads set after reset without a buffer, clear with one.
// - Top bit 0 is the user segment; top bits 11 the kernel mapped segment.
// - Unmatched user segment reference raises the user miss exception.
// - Unmatched kernel mapped reference or invalid hit raises load or store miss.
`include "tlbx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tlbx_tlb #(
    parameter bit HAS_TLB = 1'b1
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    input  wire logic [`TLBX_AW-1:0] reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    input  wire tlbx_pkg::tlbx_op_t  op_code,
    input  wire tlbx_pkg::tlbx_req_t req,
    output tlbx_pkg::tlbx_resp_t     resp,
    output logic                     translation_shutdown_flag
);
    import tlbx_pkg::*;

    localparam int N_ENTRIES = 64;

    logic [19:0]   ent_vpn [N_ENTRIES];
    logic [5:0]    ent_pid [N_ENTRIES];
    logic [19:0]   ent_pfn [N_ENTRIES];
    logic          ent_n   [N_ENTRIES];
    logic          ent_d   [N_ENTRIES];
    logic          ent_v   [N_ENTRIES];
    logic          ent_g   [N_ENTRIES];

    logic [19:0]   hi_vpn;
    logic [5:0]    hi_pid;
    logic [19:0]   lo_pfn;
    logic          lo_n;
    logic          lo_d;
    logic          lo_v;
    logic          lo_g;
    logic [5:0]    idx_sel;
    logic          idx_fail;
    logic [5:0]    rnd;

    logic          t_hit;
    logic          t_multi;
    logic [5:0]    t_idx;
    logic          p_hit;
    logic          p_multi;
    logic [5:0]    p_idx;
    logic [1:0]    seg;
    logic          is_user;
    logic          is_kmap;
    logic          is_store;
    logic          mapped_ref;
    logic          set_shutdown;
    logic          ent_we;
    logic [5:0]    ent_wsel;
    tlbx_resp_t    next_resp;

    function automatic logic match_fn(input logic [19:0] e_vpn,
                                      input logic [5:0]  e_pid,
                                      input logic        e_g,
                                      input logic [19:0] virtual_page_number,
                                      input logic [5:0]  process_tag);
        match_fn = (e_vpn == virtual_page_number) && (e_g || (e_pid == process_tag));
    endfunction

    function automatic logic [1:0] seg_fn(input logic [31:0] va);
        seg_fn = {va[`TLBX_VA_TOP2] == `TLBX_KMAP_CODE, !va[`TLBX_VA_USER]};
    endfunction

    assign seg        = seg_fn(req.vaddr);
    assign is_user    = seg[0];
    assign is_kmap    = seg[1];
    assign is_store   = (req.acc == TLBX_ACC_STORE);
    assign mapped_ref = req.valid && (is_user || is_kmap);

    // Every entry is compared at once; a second hit marks a multiple mapping.
    always_comb begin
        t_hit   = 1'b0;
        t_multi = 1'b0;
        t_idx   = 6'h00;
        for (int i = 0; i < N_ENTRIES; i++) begin
            if (match_fn(ent_vpn[i], ent_pid[i], ent_g[i], req.vaddr[`TLBX_VA_VPN], hi_pid)) begin
                t_multi = t_multi | t_hit;
                t_hit   = 1'b1;
                t_idx   = 6'(i);
            end
        end
    end

    always_comb begin
        p_hit   = 1'b0;
        p_multi = 1'b0;
        p_idx   = 6'h00;
        for (int i = 0; i < N_ENTRIES; i++) begin
            if (match_fn(ent_vpn[i], ent_pid[i], ent_g[i], hi_vpn, hi_pid)) begin
                p_multi = p_multi | p_hit;
                p_hit   = 1'b1;
                p_idx   = 6'(i);
            end
        end
    end

    assign set_shutdown = (mapped_ref && t_multi) || (op_code == TLBX_OP_PROBE && p_multi);

    // Unmapped segments leave here untouched; their own mapping lives elsewhere.
    always_comb begin
        next_resp       = '0;
        next_resp.valid = req.valid;
        next_resp.paddr = req.vaddr;
        if (mapped_ref) begin
            next_resp.mapped = 1'b1;
            // A multiple match is refused at once, so no ambiguous frame ever leaves the block.
            if (!translation_shutdown_flag && !t_multi) begin
                if (t_hit) begin
                    next_resp.hit        = 1'b1;
                    next_resp.paddr      = {ent_pfn[t_idx], req.vaddr[`TLBX_VA_OFF]};
                    next_resp.uncached   = ent_n[t_idx];
                    next_resp.writable   = ent_d[t_idx];
                    next_resp.page_valid = ent_v[t_idx];
                    if (!ent_v[t_idx]) begin
                        next_resp.store_miss = is_store;
                        next_resp.load_miss  = !is_store;
                    end else if (is_store && !ent_d[t_idx]) begin
                        next_resp.modify = 1'b1;
                    end
                end else if (is_user) begin
                    next_resp.user_miss = 1'b1;
                end else begin
                    next_resp.store_miss = is_store;
                    next_resp.load_miss  = !is_store;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resp <= '0;
        end else if (clk_en) begin
            resp <= next_resp;
        end
    end

    // A read operation in the same cycle as a bus write wins the register.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hi_vpn <= 20'h00000;
            hi_pid <= 6'h00;
        end else if (clk_en) begin
            if (op_code == TLBX_OP_READ) begin
                hi_vpn <= ent_vpn[idx_sel];
                hi_pid <= ent_pid[idx_sel];
            end else if (reg_wr && reg_addr == `TLBX_OFF_HI) begin
                hi_vpn <= reg_wdata[`TLBX_HI_VPN];
                hi_pid <= reg_wdata[`TLBX_HI_PID];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lo_pfn <= 20'h00000;
            lo_n   <= 1'b0;
            lo_d   <= 1'b0;
            lo_v   <= 1'b0;
            lo_g   <= 1'b0;
        end else if (clk_en) begin
            if (op_code == TLBX_OP_READ) begin
                lo_pfn <= ent_pfn[idx_sel];
                lo_n   <= ent_n[idx_sel];
                lo_d   <= ent_d[idx_sel];
                lo_v   <= ent_v[idx_sel];
                lo_g   <= ent_g[idx_sel];
            end else if (reg_wr && reg_addr == `TLBX_OFF_LO) begin
                lo_pfn <= reg_wdata[`TLBX_LO_PFN];
                lo_n   <= reg_wdata[`TLBX_LO_N];
                lo_d   <= reg_wdata[`TLBX_LO_D];
                lo_v   <= reg_wdata[`TLBX_LO_V];
                lo_g   <= reg_wdata[`TLBX_LO_G];
            end
        end
    end

    // A failed probe keeps the old selector so only the flag tells the story.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx_sel  <= 6'h00;
            idx_fail <= 1'b0;
        end else if (clk_en) begin
            if (op_code == TLBX_OP_PROBE) begin
                if (p_hit) begin
                    idx_sel  <= p_idx;
                    idx_fail <= 1'b0;
                end else begin
                    idx_fail <= 1'b1;
                end
            end else if (reg_wr && reg_addr == `TLBX_OFF_IDX) begin
                idx_sel  <= reg_wdata[`TLBX_IDX_SEL];
                idx_fail <= reg_wdata[`TLBX_IDX_FAIL];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rnd <= `TLBX_RND_TOP;
        end else if (clk_en) begin
            if (rnd == `TLBX_RND_FLOOR) begin
                rnd <= `TLBX_RND_TOP;
            end else begin
                rnd <= rnd - 6'h01;
            end
        end
    end

    assign ent_we   = (op_code == TLBX_OP_WRITE_IDX) || (op_code == TLBX_OP_WRITE_RND);
    assign ent_wsel = (op_code == TLBX_OP_WRITE_RND) ? rnd : idx_sel;

    // Entries only change through the write operations, never on a fault.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                ent_vpn[i] <= 20'h00000;
                ent_pid[i] <= 6'h00;
                ent_pfn[i] <= 20'h00000;
                ent_n[i]   <= 1'b0;
                ent_d[i]   <= 1'b0;
                ent_v[i]   <= 1'b0;
                ent_g[i]   <= 1'b0;
            end
        end else if (clk_en && ent_we) begin
            ent_vpn[ent_wsel] <= hi_vpn;
            ent_pid[ent_wsel] <= hi_pid;
            ent_pfn[ent_wsel] <= lo_pfn;
            ent_n[ent_wsel]   <= lo_n;
            ent_d[ent_wsel]   <= lo_d;
            ent_v[ent_wsel]   <= lo_v;
            ent_g[ent_wsel]   <= lo_g;
        end
    end

    // Without a buffer the flag comes out of reset set and nothing clears it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            translation_shutdown_flag <= !HAS_TLB;
        end else if (clk_en && set_shutdown) begin
            translation_shutdown_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                if (reg_addr == `TLBX_OFF_HI) begin
                    reg_rdata[`TLBX_HI_VPN] <= hi_vpn;
                    reg_rdata[`TLBX_HI_PID] <= hi_pid;
                end else if (reg_addr == `TLBX_OFF_LO) begin
                    reg_rdata[`TLBX_LO_PFN] <= lo_pfn;
                    reg_rdata[`TLBX_LO_N]   <= lo_n;
                    reg_rdata[`TLBX_LO_D]   <= lo_d;
                    reg_rdata[`TLBX_LO_V]   <= lo_v;
                    reg_rdata[`TLBX_LO_G]   <= lo_g;
                end else if (reg_addr == `TLBX_OFF_IDX) begin
                    reg_rdata[`TLBX_IDX_SEL]  <= idx_sel;
                    reg_rdata[`TLBX_IDX_FAIL] <= idx_fail;
                end else if (reg_addr == `TLBX_OFF_RND) begin
                    reg_rdata[`TLBX_RND_SEL] <= rnd;
                end else if (reg_addr == `TLBX_OFF_STAT) begin
                    reg_rdata[`TLBX_STAT_TS] <= translation_shutdown_flag;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence seq_rnd_floor;
        clk_en && rnd == `TLBX_RND_FLOOR;
    endsequence

    sequence seq_rnd_refill;
        rnd == `TLBX_RND_TOP;
    endsequence

    sequence seq_store_ro_hit;
        clk_en && mapped_ref && is_store && t_hit && !translation_shutdown_flag
            && ent_v[t_idx] && !ent_d[t_idx] && !t_multi;
    endsequence

    sequence seq_modify_seen;
        resp.modify && !resp.store_miss && resp.hit;
    endsequence

    a_random_range: assert property (
        rnd >= `TLBX_RND_FLOOR
    ) else $error("Random counter left its range.");

    a_random_wrap: assert property (
        seq_rnd_floor |=> seq_rnd_refill
    ) else $error("Random counter did not wrap to the top.");

    a_random_step: assert property (
        clk_en && rnd != `TLBX_RND_FLOOR |=> rnd == 6'($past(rnd) - 6'h01)
    ) else $error("Random counter did not step down by one.");

    a_shutdown_sticky: assert property (
        translation_shutdown_flag |=> translation_shutdown_flag [*2]
    ) else $error("Shutdown flag cleared without reset.");

    a_shutdown_set: assert property (
        clk_en && mapped_ref && t_multi |=> translation_shutdown_flag && !resp.hit
    ) else $error("Multiple match did not shut translation down.");

    a_probe_fail: assert property (
        clk_en && op_code == TLBX_OP_PROBE && !p_hit |=> idx_fail && $stable(idx_sel)
    ) else $error("Failed probe did not set the fail flag.");

    a_user_miss: assert property (
        clk_en && mapped_ref && is_user && !t_hit && !translation_shutdown_flag
            |=> resp.user_miss && !resp.load_miss && !resp.store_miss
    ) else $error("User segment miss not reported.");

    a_modify_trap: assert property (
        seq_store_ro_hit |=> seq_modify_seen
    ) else $error("Store to read-only page did not raise modify.");

    a_page_offset: assert property (
        clk_en && mapped_ref && t_hit && !translation_shutdown_flag
            |=> resp.paddr[`TLBX_VA_OFF] == $past(req.vaddr[`TLBX_VA_OFF])
    ) else $error("Page offset changed in translation.");

    a_reserved_zero: assert property (
        clk_en && reg_rd && reg_addr == `TLBX_OFF_HI |=> reg_rdata[5:0] == 6'h00
    ) else $error("Reserved bits of the high register read nonzero.");

endmodule

`default_nettype wire

// >>> dv/tlbx_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the pipeline: one translation request or one buffer operation per call.
module tlbx_core_model (
    input  wire logic                core_clk,
    output var  tlbx_pkg::tlbx_req_t req,
    output var  tlbx_pkg::tlbx_op_t  op_code
);
    import tlbx_pkg::*;

    initial begin
        req = '0;
        op_code = TLBX_OP_NONE;
    end

    // The address is inverted once withdrawn, so a stale value can never pass for a live one.
    task automatic translate(input logic [31:0] va, input tlbx_acc_t a);
        req <= '{valid: 1'b1, acc: a, vaddr: va};
        @(posedge core_clk);
        req <= '{valid: 1'b0, acc: a, vaddr: ~va};
    endtask

    task automatic issue(input tlbx_op_t op);
        op_code <= op;
        @(posedge core_clk);
        op_code <= TLBX_OP_NONE;
    endtask
endmodule

`default_nettype wire

// >>> dv/tlbx_tlb_tb.sv
`include "tlbx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tlbx_tlb_tb;
    import tlbx_pkg::*;

    logic                core_clk;
    logic                rst;
    logic                clk_en;
    logic [`TLBX_AW-1:0] reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [31:0]         reg_rdata;
    tlbx_op_t            op_code;
    tlbx_req_t           req;
    tlbx_resp_t          resp;
    logic                translation_shutdown_flag;
    logic [31:0]         seed;
    logic [31:0]         m_hi [64];
    logic [31:0]         m_lo [64];
    logic [31:0]         hi_r;
    logic [31:0]         d;
    logic [31:0]         r;
    logic [19:0]         virtual_page_number [16];
    logic [5:0]          ix;
    logic                sd_exp;
    logic [5:0]          rnd_m;
    logic [5:0]          rnd_w;
    int                  n_errors;
    int                  n_tests;

    tlbx_core_model tlbx_core_model_i (.core_clk(core_clk), .req(req), .op_code(op_code));

    tlbx_tlb #(.HAS_TLB(1'b1)) tlbx_tlb_i (
        .core_clk                  (core_clk),
        .rst                       (rst),
        .clk_en                    (clk_en),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .op_code                   (op_code),
        .req                       (req),
        .resp                      (resp),
        .translation_shutdown_flag (translation_shutdown_flag)
    );

    always #20 core_clk = ~core_clk;

    // Replacement counter model; it remembers the value that a random write uses.
    always @(posedge core_clk) begin
        if (rst) begin
            rnd_m <= 6'h3f;
        end else if (clk_en) begin
            rnd_m <= dec(rnd_m, 1);
            if (op_code == TLBX_OP_WRITE_RND) rnd_w <= rnd_m;
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [5:0] dec(input logic [5:0] v, input int n);
        for (int k = 0; k < n; k++) v = (v == 6'h08) ? 6'h3f : v - 6'h01;
        return v;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        if (a == `TLBX_OFF_HI) hi_r = v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
        @(posedge core_clk);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk(d, e);
        @(posedge core_clk);
    endtask

    task automatic op(input tlbx_op_t o);
        tlbx_core_model_i.issue(o);
        @(posedge core_clk);
    endtask

    task automatic write_entry(input logic [5:0] i, input logic [31:0] h, input logic [31:0] l);
        wr(`TLBX_OFF_HI, h);
        wr(`TLBX_OFF_LO, l);
        wr(`TLBX_OFF_IDX, {18'h0, i, 8'h0});
        op(TLBX_OP_WRITE_IDX);
        m_hi[i] = h;
        m_lo[i] = l;
    endtask

    task automatic tr(input logic [31:0] va, input tlbx_acc_t a);
        int nm;
        logic [31:0] lo;
        logic mp;
        logic st;
        mp = !va[31] || va[31:30] == 2'h3;
        st = a == TLBX_ACC_STORE;
        nm = 0;
        lo = '0;
        for (int k = 0; k < 64; k++) begin
            if (m_hi[k][31:12] == va[31:12] && (m_lo[k][8] || m_hi[k][11:6] == hi_r[11:6])) begin
                nm++;
                lo = m_lo[k];
            end
        end
        tlbx_core_model_i.translate(va, a);
        #1;
        chk({resp.valid, resp.mapped}, {1'b1, mp});
        if (!mp || sd_exp || nm > 1) begin
            chk({resp.hit, resp.user_miss, resp.load_miss, resp.store_miss, resp.modify, resp.paddr}, {5'h0, va});
        end else if (nm == 0) begin
            chk({resp.hit, resp.user_miss, resp.load_miss, resp.store_miss, resp.modify},
                {1'b0, !va[31], va[31] && !st, va[31] && st, 1'b0});
        end else if (nm == 1) begin
            chk({resp.hit, resp.paddr, resp.uncached, resp.writable, resp.page_valid},
                {1'b1, lo[31:12], va[11:0], lo[11:9]});
            chk({resp.user_miss, resp.load_miss, resp.store_miss, resp.modify},
                {1'b0, !lo[9] && !st, !lo[9] && st, lo[9] && !lo[10] && st});
        end
        if (nm > 1 && mp) sd_exp = 1'b1;
        chk(translation_shutdown_flag, sd_exp);
        @(posedge core_clk);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        seed = 32'h00000162;
        n_errors = 0;
        n_tests = 0;
        sd_exp = 1'b0;
        hi_r = '0;
        foreach (m_hi[k]) begin
            m_hi[k] = '0;
            m_lo[k] = '0;
        end
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(`TLBX_OFF_RND, {18'h0, 6'h3f, 8'h0});
        rdc(`TLBX_OFF_HI, 32'h0);
        rdc(`TLBX_OFF_LO, 32'h0);
        rdc(`TLBX_OFF_IDX, 32'h0);
        rdc(`TLBX_OFF_STAT, 32'h0);
        rdc(5'h14, 32'h0);
        // Reads sit two edges apart, so the k-th one sees the counter stepped down 2k times.
        for (int k = 6; k < 76; k++) rdc(`TLBX_OFF_RND, {18'h0, dec(6'h3f, 2 * k), 8'h0});
        // Four disabled edges must not step the counter.
        clk_en <= 1'b0;
        repeat (4) @(posedge core_clk);
        clk_en <= 1'b1;
        rdc(`TLBX_OFF_RND, {18'h0, dec(6'h3f, 2 * 76), 8'h0});
        $display("test reset_and_counter done");
        for (int i = 0; i < 16; i++) begin
            r = xs();
            virtual_page_number[i] = {i[0] ? 2'h3 : 2'h0, r[12:0], 1'b1, i[3:0]};
            ix = {i[3:0], 2'h3};
            d = xs();
            write_entry(ix, {virtual_page_number[i], i[1] ? 6'h2a : r[18:13], 6'h0}, {d[31:8], 8'h0});
            wr(`TLBX_OFF_HI, 32'h0);
            wr(`TLBX_OFF_LO, 32'h0);
            op(TLBX_OP_READ);
            hi_r = m_hi[ix];
            rdc(`TLBX_OFF_HI, m_hi[ix]);
            rdc(`TLBX_OFF_LO, m_lo[ix]);
            rdc(`TLBX_OFF_IDX, {18'h0, ix, 8'h0});
        end
        $display("test entry_write_read done");
        wr(`TLBX_OFF_HI, {20'h0, 6'h2a, 6'h0});
        for (int i = 0; i < 16; i++) begin
            for (int a = 0; a < 3; a++) begin
                r = xs();
                tr({virtual_page_number[i], r[11:0]}, tlbx_acc_t'(a));
            end
        end
        tr(32'h8000_1234, TLBX_ACC_LOAD);
        tr(32'ha012_3456, TLBX_ACC_STORE);
        tr(32'h0000_0fff, TLBX_ACC_FETCH);
        tr(32'hfff0_0000, TLBX_ACC_STORE);
        tr(32'h7fff_f000, TLBX_ACC_LOAD);
        $display("test translation done");
        wr(`TLBX_OFF_HI, m_hi[6'h3f]);
        op(TLBX_OP_PROBE);
        rdc(`TLBX_OFF_IDX, {18'h0, 6'h3f, 8'h0});
        wr(`TLBX_OFF_HI, {20'hfff00, 6'h2a, 6'h0});
        op(TLBX_OP_PROBE);
        rdc(`TLBX_OFF_IDX, {1'b1, 17'h0, 6'h3f, 8'h0});
        $display("test probe done");
        for (int w = 0; w < 2; w++) begin
            wr(`TLBX_OFF_HI, {16'h0010, w[3:0], 6'h15, 6'h0});
            wr(`TLBX_OFF_LO, {16'h5a5a, w[3:0], 4'h6, 8'h0});
            op(TLBX_OP_WRITE_RND);
            op(TLBX_OP_PROBE);
            rdc(`TLBX_OFF_IDX, {18'h0, rnd_w, 8'h0});
            chk({d[31], d[13:8] >= 6'h08}, 2'b01);
            m_hi[d[13:8]] = hi_r;
            m_lo[d[13:8]] = {16'h5a5a, w[3:0], 4'h6, 8'h0};
            tr({16'h0010, w[3:0], 12'habc}, TLBX_ACC_STORE);
        end
        $display("test random_write done");
        write_entry(6'h00, m_hi[6'h03], m_lo[6'h03]);
        tr({virtual_page_number[0], 12'h010}, TLBX_ACC_LOAD);
        rdc(`TLBX_OFF_STAT, 32'h1);
        wr(`TLBX_OFF_STAT, 32'h0);
        rdc(`TLBX_OFF_STAT, 32'h1);
        tr({virtual_page_number[1], 12'h020}, TLBX_ACC_FETCH);
        $display("test shutdown done");
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        sd_exp = 1'b0;
        rdc(`TLBX_OFF_RND, {18'h0, 6'h3f, 8'h0});
        rdc(`TLBX_OFF_STAT, 32'h0);
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
